// file: cpu_memory_addressing.v
// Memory addressing core: address decode, bank registers, stack, bit area and branch timing.
`timescale 1ns/1ps
`default_nettype none
`include "mem_addressing_map.vh"

// How it works
// - Indirect compare-branch-unequal: three bytes, four cycles not taken, five taken.
// - Bank register decrement-branch-nonzero: two bytes, two or three cycles.
// - Direct decrement-branch-nonzero: three bytes, three or four cycles.
// - Relative targets add signed 8-bit offset to next instruction address.
// - Direct address below 0x80 hits RAM, at or above hits registers.
// - Page target replaces low 11 bits of next instruction address.
// - Long target loads full 16-bit address.
// - Unused opcode 0xA5 behaves as no-operation.
// - Flash spans 0x0000-0x3FFF; addresses above 0x3E00 are reserved.
// - External data writes go to program memory while store-enable bit set.
// - Indirect above 0x7F hits upper RAM; direct hits special registers.
// - Bank registers map into RAM 0x00-0x1F, bank from status bits three, four.
// - Indirect modes take address from the caller-supplied index register value on acc_addr_in.
// - RAM 0x20-0x2F bytes also reachable as bits 0x00-0x7F.
// - Bit versus byte access chosen by operand type, not address.
// - Push writes at pointer plus one, then increments pointer.
// - Reset loads stack pointer with 0x07.
// - Stack may sit anywhere in 256-byte RAM and use all of it.
// - Special registers at addresses ending 0x0 or 0x8 allow bit access.
module cpu_memory_addressing #(
	parameter PC_WIDTH = 16
) (
	// Clock and reset
	input wire ref_clk_in,
	input wire reset_n_in,
	// Instruction issue
	input wire instr_valid_in,
	input wire [7:0] opcode_in,
	input wire [7:0] operand1_in,
	input wire [7:0] operand2_in,
	input wire [PC_WIDTH-1:0] pc_in,
	// Data-space access request
	input wire acc_valid_in,
	input wire acc_write_in,
	input wire acc_indirect_in,
	input wire acc_bit_in,
	input wire acc_bank_reg_in,
	input wire acc_push_in,
	input wire acc_pop_in,
	input wire [7:0] acc_addr_in,
	input wire [7:0] acc_wdata_in,
	input wire acc_bit_value_in,
	// External data move request
	input wire xdata_write_in,
	input wire [PC_WIDTH-1:0] xdata_addr_in,
	input wire [7:0] xdata_wdata_in,
	// Results
	output reg [7:0] acc_rdata_out,
	output reg acc_sfr_hit_out,
	output reg acc_bit_illegal_out,
	output reg [7:0] stack_pointer_out,
	output reg [7:0] program_status_word_out,
	output reg busy_out,
	output reg [PC_WIDTH-1:0] next_pc_out,
	output reg next_pc_valid_out,
	output reg branch_taken_out,
	output reg [2:0] cycle_count_out,
	output reg prog_write_out,
	output reg [PC_WIDTH-1:0] prog_addr_out,
	output reg [7:0] prog_data_out,
	output reg prog_reserved_out,
	output reg xdata_write_out,
	output reg [PC_WIDTH-1:0] xdata_addr_out,
	output reg [7:0] xdata_wdata_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Registers and storage

	reg [7:0] stack_pointer_reg;
	reg [7:0] program_status_word_reg;
	reg [7:0] program_store_control_reg;
	reg [2:0] wait_reg;
	wire [7:0] ram_rdata;
	reg ram_we;
	reg [7:0] ram_waddr;
	reg [7:0] ram_wdata;
	reg [7:0] ram_raddr;
	// Decrement-and-branch operand, its decremented value and the write-back strobe.
	reg [7:0] branch_operand;
	reg [7:0] dec_value;
	reg dec_wr;

	data_ram #(
		.DEPTH(256)
	) data_ram_i (
		.ref_clk_in(ref_clk_in),
		.wr_en_in(ram_we),
		.wr_addr_in(ram_waddr),
		.wr_data_in(ram_wdata),
		.rd_addr_in(ram_raddr),
		.rd_data_out(ram_rdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Address decode for data accesses

	wire [1:0] bank_sel = {program_status_word_reg[`BANK_SELECT_HIGH_BIT],
		program_status_word_reg[`BANK_SELECT_LOW_BIT]};
	reg [7:0] eff_addr;
	reg is_sfr;
	reg [2:0] bit_pos;
	reg sfr_bit_ok;
	reg [7:0] sfr_rdata;
	reg [7:0] stack_pointer_next;

	always @* begin
		eff_addr = acc_addr_in;
		is_sfr = 1'b0;
		bit_pos = 3'd0;
		if (acc_push_in) begin
			eff_addr = stack_pointer_reg + 8'h01;
		end else if (acc_pop_in) begin
			eff_addr = stack_pointer_reg;
		end else if (acc_bank_reg_in) begin
			eff_addr = {3'b000, bank_sel, acc_addr_in[2:0]};
		end else if (acc_bit_in) begin
			bit_pos = acc_addr_in[2:0];
			if (acc_addr_in[7]) begin
				eff_addr = {acc_addr_in[7:3], 3'b000};
				is_sfr = 1'b1;
			end else begin
				eff_addr = `BIT_AREA_BASE + {4'h0, acc_addr_in[6:3]};
			end
		end else if (acc_indirect_in) begin
			// The caller supplies the index register value; upper half hits RAM.
			eff_addr = acc_addr_in;
		end else if (acc_addr_in >= `SFR_SPACE_BASE) begin
			is_sfr = 1'b1;
		end
	end

	always @* begin
		// Bit access in register space exists only at column 0 or 8.
		// A bit address always lands on a column 0 or 8 byte, so the flag only rises if the
		// bit decode itself goes wrong.
		sfr_bit_ok = (eff_addr[2:0] == 3'd0);
		case (eff_addr)
			`STACK_POINTER_ADDR: sfr_rdata = stack_pointer_reg;
			`PROGRAM_STATUS_WORD_ADDR: sfr_rdata = program_status_word_reg;
			`PROGRAM_STORE_CONTROL_ADDR: sfr_rdata = program_store_control_reg;
			// Unoccupied addresses read zero here; software should not rely on it.
			default: sfr_rdata = 8'h00;
		endcase
	end

	always @* begin
		// The decremented byte comes through the same decode as a data access.
		branch_operand = is_sfr ? sfr_rdata : ram_rdata;
		dec_value = branch_operand - 8'h01;
		// Write-back happens at the issue edge, so the next issue never sees a stale byte.
		dec_wr = reset_n_in && instr_valid_in && (wait_reg == 3'd0) &&
			((opcode_in[7:3] == `OPC_DECREMENT_BRANCH_NONZERO_REG_HI) || (opcode_in == `OPC_DECREMENT_BRANCH_NONZERO_DIR));
	end

	always @* begin
		ram_raddr = eff_addr;
		ram_we = 1'b0;
		ram_waddr = eff_addr;
		ram_wdata = acc_wdata_in;
		if (acc_valid_in && acc_write_in && !is_sfr) begin
			ram_we = 1'b1;
			if (acc_bit_in) begin
				ram_wdata = ram_rdata;
				ram_wdata[bit_pos] = acc_bit_value_in;
			end
		end
		if (dec_wr && !is_sfr) begin
			// The loop counter in RAM is stored back decremented.
			ram_we = 1'b1;
			ram_wdata = dec_value;
		end
		stack_pointer_next = stack_pointer_reg;
		if (acc_valid_in && acc_push_in) begin
			stack_pointer_next = stack_pointer_reg + 8'h01;
		end else if (acc_valid_in && acc_pop_in) begin
			stack_pointer_next = stack_pointer_reg - 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register file and access results

	always @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			stack_pointer_reg <= `STACK_POINTER_RESET;
			program_status_word_reg <= `PSW_RESET;
			program_store_control_reg <= `PROGRAM_STORE_CONTROL_RESET;
			acc_rdata_out <= 8'h00;
			acc_sfr_hit_out <= 1'b0;
			acc_bit_illegal_out <= 1'b0;
			stack_pointer_out <= `STACK_POINTER_RESET;
			program_status_word_out <= `PSW_RESET;
		end else begin
			stack_pointer_reg <= stack_pointer_next;
			if (acc_valid_in && acc_write_in && is_sfr) begin
				if (acc_bit_in) begin
					case (eff_addr)
						`PROGRAM_STATUS_WORD_ADDR: program_status_word_reg[bit_pos] <= acc_bit_value_in;
						default: ;
					endcase
				end else if (eff_addr == `STACK_POINTER_ADDR) begin
					stack_pointer_reg <= acc_wdata_in;
				end else if (eff_addr == `PROGRAM_STATUS_WORD_ADDR) begin
					program_status_word_reg <= acc_wdata_in;
				end else if (eff_addr == `PROGRAM_STORE_CONTROL_ADDR) begin
					program_store_control_reg <= acc_wdata_in;
				end
			end
			// A loop counter held in a special register is stored back decremented as well.
			if (dec_wr && is_sfr) begin
				if (eff_addr == `STACK_POINTER_ADDR) begin
					stack_pointer_reg <= dec_value;
				end else if (eff_addr == `PROGRAM_STATUS_WORD_ADDR) begin
					program_status_word_reg <= dec_value;
				end else if (eff_addr == `PROGRAM_STORE_CONTROL_ADDR) begin
					program_store_control_reg <= dec_value;
				end
			end
			if (acc_valid_in) begin
				acc_sfr_hit_out <= is_sfr;
				acc_bit_illegal_out <= acc_bit_in && is_sfr && !sfr_bit_ok;
				if (acc_bit_in) begin
					acc_rdata_out <= {7'h00, is_sfr ? sfr_rdata[bit_pos] : ram_rdata[bit_pos]};
				end else begin
					acc_rdata_out <= is_sfr ? sfr_rdata : ram_rdata;
				end
			end
			stack_pointer_out <= stack_pointer_next;
			program_status_word_out <= program_status_word_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Program store write steering

	always @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			prog_write_out <= 1'b0;
			prog_addr_out <= {PC_WIDTH{1'b0}};
			prog_data_out <= 8'h00;
			prog_reserved_out <= 1'b0;
			xdata_write_out <= 1'b0;
			xdata_addr_out <= {PC_WIDTH{1'b0}};
			xdata_wdata_out <= 8'h00;
		end else begin
			// Store-enable steers the move into flash instead of data space.
			prog_write_out <= xdata_write_in && program_store_control_reg[`PROGRAM_STORE_CONTROL_WRITE_ENABLE_BIT];
			xdata_write_out <= xdata_write_in && !program_store_control_reg[`PROGRAM_STORE_CONTROL_WRITE_ENABLE_BIT];
			prog_addr_out <= xdata_addr_in;
			prog_data_out <= xdata_wdata_in;
			xdata_addr_out <= xdata_addr_in;
			xdata_wdata_out <= xdata_wdata_in;
			// Writes beyond the usable flash are flagged, but this block still raises prog_write_out for them.
			// Ordinary data moves may use any address, so only program-store writes are flagged.
			prog_reserved_out <= xdata_write_in && program_store_control_reg[`PROGRAM_STORE_CONTROL_WRITE_ENABLE_BIT] &&
				(xdata_addr_in > `FLASH_RESERVED_ABOVE);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Branch target and cycle timing

	reg [PC_WIDTH-1:0] pc_seq;
	reg [PC_WIDTH-1:0] target;
	reg taken;
	reg [2:0] cycles;

	always @* begin
		pc_seq = pc_in + 16'd1;
		target = pc_seq;
		taken = 1'b0;
		cycles = `CYC_NOP;
		if (opcode_in[4:0] == `OPC_AJMP_LOW || opcode_in[4:0] == `OPC_ACALL_LOW) begin
			pc_seq = pc_in + 16'd2;
			target = {pc_seq[PC_WIDTH-1:11], opcode_in[7:5], operand1_in};
			taken = 1'b1;
			cycles = `CYC_AJMP;
		end else if (opcode_in == `OPC_LJMP || opcode_in == `OPC_LCALL) begin
			pc_seq = pc_in + 16'd3;
			target = {operand1_in, operand2_in};
			taken = 1'b1;
			cycles = `CYC_LJMP;
		end else if (opcode_in == `OPC_SJMP) begin
			pc_seq = pc_in + 16'd2;
			target = pc_seq + {{8{operand1_in[7]}}, operand1_in};
			taken = 1'b1;
			cycles = `CYC_SJMP;
		end else if (opcode_in == `OPC_COMPARE_BRANCH_UNEQUAL_IND_0 || opcode_in == `OPC_COMPARE_BRANCH_UNEQUAL_IND_1) begin
			pc_seq = pc_in + 16'd3;
			taken = (ram_rdata != operand1_in);
			target = taken ? pc_seq + {{8{operand2_in[7]}}, operand2_in} : pc_seq;
			cycles = taken ? `CYC_COMPARE_BRANCH_UNEQUAL_IND_T : `CYC_COMPARE_BRANCH_UNEQUAL_IND_NT;
		end else if (opcode_in[7:3] == `OPC_DECREMENT_BRANCH_NONZERO_REG_HI) begin
			pc_seq = pc_in + 16'd2;
			taken = (dec_value != 8'h00);
			target = taken ? pc_seq + {{8{operand1_in[7]}}, operand1_in} : pc_seq;
			cycles = taken ? `CYC_DECREMENT_BRANCH_NONZERO_REG_T : `CYC_DECREMENT_BRANCH_NONZERO_REG_NT;
		end else if (opcode_in == `OPC_DECREMENT_BRANCH_NONZERO_DIR) begin
			pc_seq = pc_in + 16'd3;
			taken = (dec_value != 8'h00);
			target = taken ? pc_seq + {{8{operand2_in[7]}}, operand2_in} : pc_seq;
			cycles = taken ? `CYC_DECREMENT_BRANCH_NONZERO_DIR_T : `CYC_DECREMENT_BRANCH_NONZERO_DIR_NT;
		end else begin
			// Unused opcode and no-operation share this single-cycle path.
			pc_seq = pc_in + 16'd1;
			target = pc_seq;
		end
	end

	// The wait counter holds the cycles still owed by the issued instruction; an issue request
	// arriving while it is non-zero is ignored, so the caller must watch busy_out.
	always @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			wait_reg <= 3'd0;
			busy_out <= 1'b0;
			next_pc_out <= {PC_WIDTH{1'b0}};
			next_pc_valid_out <= 1'b0;
			branch_taken_out <= 1'b0;
			cycle_count_out <= 3'd0;
		end else begin
			next_pc_valid_out <= 1'b0;
			if (wait_reg != 3'd0) begin
				wait_reg <= wait_reg - 3'd1;
				busy_out <= (wait_reg != 3'd1);
				next_pc_valid_out <= (wait_reg == 3'd1);
			end else if (instr_valid_in) begin
				next_pc_out <= target;
				branch_taken_out <= taken;
				cycle_count_out <= cycles;
				wait_reg <= cycles - 3'd1;
				busy_out <= (cycles != 3'd1);
				next_pc_valid_out <= (cycles == 3'd1);
			end
		end
	end

endmodule // cpu_memory_addressing
`default_nettype wire

// file: cpu_memory_addressing_bench.sv
// Self-checking bench for the memory addressing core with its flash partner.
`timescale 1ns/1ps
`default_nettype none
module cpu_memory_addressing_bench;
	localparam logic [4:0] RD = 5'h00, RI = 5'h08, WR = 5'h10, WI = 5'h18, WB = 5'h14, RB = 5'h04, WK = 5'h12, PU = 5'h11;
	logic ref_clk_in = 1'b0, reset_n_in = 1'b0, instr_valid_in = 1'b0, xdata_write_in = 1'b0;
	logic acc_valid_in = 1'b0, acc_write_in = 1'b0, acc_indirect_in = 1'b0, acc_bit_in = 1'b0;
	logic acc_bank_reg_in = 1'b0, acc_push_in = 1'b0, acc_pop_in = 1'b0, acc_bit_value_in = 1'b0, pw, xw, rv;
	logic [7:0] opcode_in = 8'h00, operand1_in = 8'h00, operand2_in = 8'h00;
	logic [7:0] acc_addr_in = 8'h00, acc_wdata_in = 8'h00, xdata_wdata_in = 8'h00;
	logic [15:0] pc_in = 16'h0000, xdata_addr_in = 16'h0000;
	wire [7:0] acc_rdata_out, stack_pointer_out, prog_data_out, flash_q, program_status_word_out, xdata_wdata_out;
	wire [15:0] next_pc_out, prog_addr_out, xdata_addr_out;
	wire [2:0] cycle_count_out;
	wire acc_sfr_hit_out, acc_bit_illegal_out, busy_out, next_pc_valid_out, branch_taken_out;
	wire prog_write_out, prog_reserved_out, xdata_write_out;
	int n_fail = 0, num_checks = 0, cyc = 0, n;
	cpu_memory_addressing cpu_memory_addressing_i (.ref_clk_in, .reset_n_in, .instr_valid_in, .opcode_in, .operand1_in,
		.operand2_in, .pc_in, .acc_valid_in, .acc_write_in, .acc_indirect_in, .acc_bit_in, .acc_bank_reg_in,
		.acc_push_in, .acc_pop_in, .acc_addr_in, .acc_wdata_in, .acc_bit_value_in, .xdata_write_in,
		.xdata_addr_in, .xdata_wdata_in, .acc_rdata_out, .acc_sfr_hit_out, .acc_bit_illegal_out,
		.stack_pointer_out, .program_status_word_out, .busy_out, .next_pc_out, .next_pc_valid_out,
		.branch_taken_out, .cycle_count_out, .prog_write_out, .prog_addr_out, .prog_data_out, .prog_reserved_out,
		.xdata_write_out, .xdata_addr_out, .xdata_wdata_out);
	flash_store flash_store_i (.ref_clk_in, .wr_in(prog_write_out), .addr_in(prog_addr_out), .data_in(prog_data_out),
		.rd_addr_in(16'h0100), .rd_data_out(flash_q));
	always #50 ref_clk_in = ~ref_clk_in;
	// The whole sequence needs about 150 cycles; this ceiling only catches a hang.
	always @(posedge ref_clk_in) if (++cyc == 3000) begin
		n_fail++;
		close_out();
	end
	////////////////////////////////////////////////////////////////
	task automatic close_out;
		if (n_fail == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic [4:0] f, input logic [7:0] a, d);
		@(posedge ref_clk_in);
		{acc_valid_in, acc_write_in, acc_indirect_in, acc_bit_in, acc_bank_reg_in, acc_push_in} <= {1'b1, f};
		{acc_addr_in, acc_wdata_in, acc_bit_value_in} <= {a, d, d[0]};
		@(posedge ref_clk_in);
		acc_valid_in <= 1'b0;
		@(posedge ref_clk_in);
		#1;
	endtask
	task automatic ins(input logic [7:0] op, o1, o2, input logic [15:0] pc, input logic [7:0] ra, input logic [4:0] f);
		@(posedge ref_clk_in);
		{instr_valid_in, opcode_in, operand1_in, operand2_in, pc_in} <= {1'b1, op, o1, o2, pc};
		{acc_addr_in, acc_indirect_in, acc_bit_in, acc_bank_reg_in, acc_push_in} <= {ra, f[3:0]};
		@(posedge ref_clk_in);
		instr_valid_in <= 1'b0;
		// A one-cycle instruction ends right after its issue edge, so look before waiting.
		for (n = 1; n < 9; n++) begin
			#1;
			if (next_pc_valid_out === 1'b1) break;
			@(posedge ref_clk_in);
		end
	endtask
	task automatic chi(input int c, input logic [15:0] p);
		chk(n, c);
		chk(cycle_count_out, c);
		chk(next_pc_out, p);
	endtask
	task automatic xd(input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		{xdata_write_in, xdata_addr_in, xdata_wdata_in} <= {1'b1, a, d};
		@(posedge ref_clk_in);
		xdata_write_in <= 1'b0;
		{pw, xw, rv} = 3'b000;
		repeat (3) begin
			#1;
			{pw, xw, rv} = {pw, xw, rv} | {prog_write_out, xdata_write_out, prog_reserved_out};
			@(posedge ref_clk_in);
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge ref_clk_in);
		reset_n_in <= 1'b1;
		#1;
		chk(stack_pointer_out, 8'h07);
		acc(RD, 8'h81, 8'h00);
		chk({acc_sfr_hit_out, acc_rdata_out}, 9'h107);
		acc(RD, 8'h7F, 8'h00);
		chk(acc_sfr_hit_out, 1'b0);
		acc(WI, 8'h81, 8'h33);
		acc(RD, 8'h81, 8'h00);
		chk(acc_rdata_out, 8'h07);
		acc(RI, 8'h81, 8'h00);
		chk(acc_rdata_out, 8'h33);
		acc(PU, 8'h00, 8'h77);
		chk(stack_pointer_out, 8'h08);
		acc(RD, 8'h08, 8'h00);
		chk(acc_rdata_out, 8'h77);
		acc(WR, 8'h81, 8'hFF);
		acc(PU, 8'h00, 8'h44);
		acc(RD, 8'h00, 8'h00);
		chk({stack_pointer_out, acc_rdata_out}, 16'h0044);
		@(posedge ref_clk_in);
		acc_pop_in <= 1'b1;
		acc(RD, 8'h00, 8'h00);
		@(posedge ref_clk_in);
		acc_pop_in <= 1'b0;
		chk({stack_pointer_out, acc_rdata_out}, 16'hFF44);
		acc(WR, 8'h22, 8'h00);
		acc(WB, 8'h13, 8'h01);
		acc(RD, 8'h22, 8'h00);
		chk(acc_rdata_out, 8'h08);
		acc(RB, 8'h13, 8'h00);
		chk(acc_rdata_out[0], 1'b1);
		acc(WR, 8'hD0, 8'h10);
		acc(WK, 8'h03, 8'h01);
		acc(RD, 8'h13, 8'h00);
		chk(acc_rdata_out, 8'h01);
		chk(program_status_word_out, 8'h10);
		ins(8'h00, 8'h00, 8'h00, 16'h0100, 8'h00, RD);
		chi(1, 16'h0101);
		ins(8'hA5, 8'h00, 8'h00, 16'h0200, 8'h00, RD);
		chi(1, 16'h0201);
		ins(8'h80, 8'hFE, 8'h00, 16'h0300, 8'h00, RD);
		chi(3, 16'h0300);
		chk(branch_taken_out, 1'b1);
		ins(8'hE1, 8'h34, 8'h00, 16'h17FE, 8'h00, RD);
		chi(3, 16'h1F34);
		ins(8'h02, 8'h3A, 8'hBC, 16'h0600, 8'h00, RD);
		chi(4, 16'h3ABC);
		ins(8'hDB, 8'h10, 8'h00, 16'h0400, 8'h03, WK);
		chi(2, 16'h0402);
		chk(branch_taken_out, 1'b0);
		ins(8'hDB, 8'h10, 8'h00, 16'h0400, 8'h03, WK);
		chi(3, 16'h0412);
		chk(branch_taken_out, 1'b1);
		ins(8'hD5, 8'h13, 8'hF0, 16'h0500, 8'h13, RD);
		chi(4, 16'h04F3);
		acc(RD, 8'h13, 8'h00);
		chk(acc_rdata_out, 8'hFE);
		acc(WI, 8'h90, 8'h5A);
		ins(8'hB6, 8'h5A, 8'h20, 16'h0700, 8'h90, RI);
		chi(4, 16'h0703);
		chk(branch_taken_out, 1'b0);
		ins(8'hB6, 8'h5B, 8'h20, 16'h0700, 8'h90, RI);
		chi(5, 16'h0723);
		chk(branch_taken_out, 1'b1);
		xd(16'h0100, 8'hC3);
		chk({pw, xw}, 2'b01);
		chk(xdata_addr_out, 16'h0100);
		chk(xdata_wdata_out, 8'hC3);
		acc(WR, 8'h8F, 8'h01);
		xd(16'h0100, 8'hC3);
		chk({pw, xw, rv, flash_q}, 11'h4C3);
		xd(16'h3E00, 8'h11);
		chk(rv, 1'b0);
		xd(16'h3F00, 8'h22);
		chk(rv, 1'b1);
		acc(WB, 8'hD3, 8'h01);
		chk({acc_sfr_hit_out, acc_bit_illegal_out}, 2'b10);
		acc(RD, 8'hD0, 8'h00);
		chk(acc_rdata_out, 8'h18);
		acc(RB, 8'hD4, 8'h00);
		chk(acc_rdata_out, 8'h01);
		close_out();
	end
endmodule // cpu_memory_addressing_bench
`default_nettype wire

// file: cpu_memory_addressing_checker.sv
// Concurrent property checker for the memory addressing core.
`timescale 1ns/1ps
`default_nettype none
module cpu_memory_addressing_checker #(
	parameter PC_WIDTH = 16
) (
	input wire ref_clk_in,
	input wire reset_n_in,
	input wire instr_valid_in,
	input wire [7:0] opcode_in,
	input wire [7:0] operand1_in,
	input wire [7:0] operand2_in,
	input wire [PC_WIDTH-1:0] pc_in,
	input wire acc_valid_in,
	input wire acc_push_in,
	input wire [7:0] stack_pointer_out,
	input wire busy_out,
	input wire [PC_WIDTH-1:0] next_pc_out,
	input wire branch_taken_out,
	input wire [2:0] cycle_count_out,
	input wire xdata_write_in,
	input wire prog_write_out,
	input wire xdata_write_out,
	input wire prog_reserved_out,
	input wire [PC_WIDTH-1:0] prog_addr_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);
	wire issue = instr_valid_in && !busy_out;
	wire [PC_WIDTH-1:0] seq_pc = pc_in + 2'd2;
	wire [PC_WIDTH-1:0] rel_pc = seq_pc + {{(PC_WIDTH-8){operand1_in[7]}}, operand1_in};
	wire [PC_WIDTH-1:0] page_pc = {seq_pc[PC_WIDTH-1:11], opcode_in[7:5], operand1_in};
	wire [PC_WIDTH-1:0] long_pc = {operand1_in, operand2_in};
	reg [7:0] sp_want;
	always @(posedge ref_clk_in) if (acc_valid_in && acc_push_in) sp_want <= stack_pointer_out + 8'h01;
	property p_sp_reset; disable iff (1'b0) !reset_n_in ##1 !reset_n_in |=> stack_pointer_out == 8'h07; endproperty
	a_sp_reset: assert property (p_sp_reset) else $error("stack pointer not reset");
	property p_push; acc_valid_in && acc_push_in |-> ##[1:2] stack_pointer_out == sp_want; endproperty
	a_push: assert property (p_push) else $error("push did not step pointer");
	property p_compare_branch_unequal; issue && opcode_in[7:1] == 7'h5B |=> cycle_count_out == (branch_taken_out ? 3'd5 : 3'd4); endproperty
	a_compare_branch_unequal: assert property (p_compare_branch_unequal) else $error("compare branch count");
	property p_decrement_branch_nonzero_reg; issue && opcode_in[7:3] == 5'h1B |=> cycle_count_out == (branch_taken_out ? 3'd3 : 3'd2); endproperty
	a_decrement_branch_nonzero_reg: assert property (p_decrement_branch_nonzero_reg) else $error("register decrement count");
	property p_decrement_branch_nonzero_dir; issue && opcode_in == 8'hD5 |=> cycle_count_out == (branch_taken_out ? 3'd4 : 3'd3); endproperty
	a_decrement_branch_nonzero_dir: assert property (p_decrement_branch_nonzero_dir) else $error("direct decrement count");
	property p_unused; issue && opcode_in == 8'hA5 |=> cycle_count_out == 3'd1 && next_pc_out == $past(pc_in) + 1'b1; endproperty
	a_unused: assert property (p_unused) else $error("unused opcode not idle");
	property p_rel; issue && opcode_in == 8'h80 |=> next_pc_out == $past(rel_pc); endproperty
	a_rel: assert property (p_rel) else $error("relative target wrong");
	property p_page; issue && opcode_in[4:0] == 5'h01 |=> next_pc_out == $past(page_pc); endproperty
	a_page: assert property (p_page) else $error("page target wrong");
	property p_long; issue && opcode_in == 8'h02 |=> next_pc_out == $past(long_pc); endproperty
	a_long: assert property (p_long) else $error("long target wrong");
	property p_store; xdata_write_in |=> prog_write_out != xdata_write_out; endproperty
	a_store: assert property (p_store) else $error("store path not exclusive");
	property p_resv; prog_reserved_out |-> prog_write_out && prog_addr_out > 16'h3E00; endproperty
	a_resv: assert property (p_resv) else $error("reserved flag wrong");
	property p_busy; issue |=> busy_out == (cycle_count_out != 3'd1); endproperty
	a_busy: assert property (p_busy) else $error("busy does not match cycle count");
endmodule // cpu_memory_addressing_checker
////////////////////////////////////////////////////////////////
bind cpu_memory_addressing cpu_memory_addressing_checker #(.PC_WIDTH(PC_WIDTH)) cpu_memory_addressing_checker_i (
	.ref_clk_in, .reset_n_in, .instr_valid_in, .opcode_in, .operand1_in, .operand2_in, .pc_in, .acc_valid_in,
	.acc_push_in, .stack_pointer_out, .busy_out, .next_pc_out, .branch_taken_out, .cycle_count_out,
	.xdata_write_in, .prog_write_out, .xdata_write_out, .prog_reserved_out, .prog_addr_out);
`default_nettype wire

// file: data_ram.v
// Flip-flop storage for the 256-byte internal data RAM.
`timescale 1ns/1ps
`default_nettype none
module data_ram #(
	parameter DEPTH = 256
) (
	input wire ref_clk_in,
	input wire wr_en_in,
	input wire [7:0] wr_addr_in,
	input wire [7:0] wr_data_in,
	input wire [7:0] rd_addr_in,
	output wire [7:0] rd_data_out
);
	reg [7:0] mem_reg [0:DEPTH-1];
	// No reset on storage: RAM contents are undefined after reset, as in silicon.
	always @(posedge ref_clk_in) begin
		if (wr_en_in) begin
			mem_reg[wr_addr_in] <= wr_data_in;
		end
	end
	assign rd_data_out = mem_reg[rd_addr_in];
endmodule // data_ram
`default_nettype wire

// file: flash_store.sv
// Behavioural program flash array that takes program-store writes.
`timescale 1ns/1ps
`default_nettype none
module flash_store (
	input wire logic ref_clk_in,
	input wire logic wr_in,
	input wire logic [15:0] addr_in,
	input wire logic [7:0] data_in,
	input wire logic [15:0] rd_addr_in,
	output logic [7:0] rd_data_out
);
	// Erased cells read as all ones; writes past the array are dropped.
	logic [7:0] mem [0:16383];
	initial for (int i = 0; i < 16384; i++) mem[i] = 8'hFF;
	always @(posedge ref_clk_in) if (wr_in && addr_in <= 16'h3FFF) mem[addr_in[13:0]] <= data_in;
	assign rd_data_out = mem[rd_addr_in[13:0]];
endmodule // flash_store
`default_nettype wire

// file: mem_addressing_map.vh
// Address map, field positions, reset values and cycle counts of the memory addressing block.
`ifndef MEM_ADDRESSING_MAP_VH
`define MEM_ADDRESSING_MAP_VH

`define STACK_POINTER_ADDR 8'h81
`define PROGRAM_STATUS_WORD_ADDR 8'hD0
`define PROGRAM_STORE_CONTROL_ADDR 8'h8F
`define STACK_POINTER_RESET 8'h07
`define PSW_RESET 8'h00
`define PROGRAM_STORE_CONTROL_RESET 8'h00
`define PROGRAM_STORE_CONTROL_WRITE_ENABLE_BIT 0
`define BANK_SELECT_LOW_BIT 3
`define BANK_SELECT_HIGH_BIT 4
`define SFR_SPACE_BASE 8'h80
`define BIT_AREA_BASE 8'h20
`define FLASH_LAST_ADDR 16'h3FFF
`define FLASH_RESERVED_ABOVE 16'h3E00

`define OPC_NOP 8'h00
`define OPC_UNUSED 8'hA5
`define OPC_AJMP_LOW 5'h01
`define OPC_ACALL_LOW 5'h11
`define OPC_LJMP 8'h02
`define OPC_LCALL 8'h12
`define OPC_SJMP 8'h80
`define OPC_COMPARE_BRANCH_UNEQUAL_IND_0 8'hB6
`define OPC_COMPARE_BRANCH_UNEQUAL_IND_1 8'hB7
`define OPC_DECREMENT_BRANCH_NONZERO_DIR 8'hD5
`define OPC_DECREMENT_BRANCH_NONZERO_REG_HI 5'h1B

`define CYC_COMPARE_BRANCH_UNEQUAL_IND_NT 3'd4
`define CYC_COMPARE_BRANCH_UNEQUAL_IND_T 3'd5
`define CYC_DECREMENT_BRANCH_NONZERO_REG_NT 3'd2
`define CYC_DECREMENT_BRANCH_NONZERO_REG_T 3'd3
`define CYC_DECREMENT_BRANCH_NONZERO_DIR_NT 3'd3
`define CYC_DECREMENT_BRANCH_NONZERO_DIR_T 3'd4
`define CYC_NOP 3'd1
`define CYC_AJMP 3'd3
`define CYC_LJMP 3'd4
`define CYC_SJMP 3'd3

`endif
